// ===== rtl/cbsi_ctrl.v
`timescale 1ns/100ps
`include "cbsi_defs.vh"

module cbsi_ctrl #(
    parameter NARROW_BUS = 1
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        irq_n,
    input  wire        nmi_n,
    input  wire        abort_n,
    input  wire        set_ovf_n,
    input  wire        rdy_in,
    output wire        rdy_out,
    output wire        rdy_oe,
    input  wire        instr_boundary,
    input  wire [1:0]  core_kind,
    input  wire        core_write,
    input  wire        rmw_final,
    output wire        core_stall,
    output wire        commit_block,
    output wire        seq_active,
    output reg  [23:0] seq_addr,
    output wire [23:0] stack_addr,
    output reg         phi2_out,
    output reg         phi1_n_out,
    output wire        legacy_out,
    output reg         width_out,
    output reg         rw_out,
    output wire        data_address_valid,
    output wire        program_address_valid,
    output wire        opcode_fetch_marker,
    output reg         vector_fetch_flag_n,
    output wire        memory_lock_out_n
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SEQ  = 1'b1;

    reg  [7:0]  p_q;
    reg         e_q;
    reg  [7:0]  code_bank_reg_q;
    reg  [7:0]  data_bank_reg_q;
    reg  [15:0] direct_q;
    reg  [15:0] sp_q;
    reg  [7:0]  xh_q;
    reg  [7:0]  yh_q;
    reg         state_q;
    reg  [2:0]  cnt_q;
    reg  [2:0]  cause_q;
    reg         rst_pend_q;
    reg         nmi_pend_q;
    reg         nmi_prev_q;
    reg         so_prev_q;
    reg         abort_lat_q;
    reg         brk_pend_q;
    reg         cop_pend_q;
    reg         sleeping_q;
    reg         woke_q;
    reg         stopped_q;
    reg         stall_q;
    reg  [2:0]  lock_cnt_q;
    reg  [1:0]  kind_q;
    reg         take;
    reg  [2:0]  cause_d;
    reg  [1:0]  kind_d;
    reg         rw_d;
    reg         vp_n_d;
    reg  [23:0] addr_d;
    wire [23:0] vec_base;
    wire [2:0]  last_cnt;
    wire [2:0]  vec_cnt;
    wire        halt_cond;
    wire        irq_req;
    wire        wake;
    wire        at_bound;
    wire        start;
    wire        pushing;
    wire        seq_go;
    wire        seq_end;
    wire        wr_ops;

    ////////////////////////////////////////////////////////////////////
    // vector lookup
    cbsi_vec_sel u_vec (
        .cause  (cause_q),
        .legacy (e_q),
        .vec    (vec_base)
    );

    ////////////////////////////////////////////////////////////////////
    // ready, halt and stall
    assign halt_cond  = ~rdy_in & ~(NARROW_BUS != 0 && e_q && core_write);
    assign core_stall = stopped_q | stall_q | halt_cond;
    assign rdy_oe     = sleeping_q;
    assign rdy_out    = 1'b0;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stall_q <= 1'b0;
        end else if (halt_cond) begin
            stall_q <= 1'b1;
        end else if (rdy_in && phi2_out && !stopped_q) begin
            stall_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output clocks
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phi2_out   <= 1'b0;
            phi1_n_out <= 1'b1;
        end else if (stopped_q) begin
            phi2_out   <= 1'b1;
            phi1_n_out <= 1'b0;
        end else begin
            phi2_out   <= ~phi2_out;
            phi1_n_out <= phi2_out;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt sources
    assign irq_req  = ~irq_n & ~p_q[`CBSI_P_I];
    assign wake     = ~irq_n | nmi_pend_q | abort_lat_q;
    assign at_bound = instr_boundary | woke_q;
    assign wr_ops   = reg_wr && reg_addr == `CBSI_OFS_OPS;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_prev_q  <= 1'b1;
            nmi_pend_q  <= 1'b0;
            abort_lat_q <= 1'b0;
            brk_pend_q  <= 1'b0;
            cop_pend_q  <= 1'b0;
            sleeping_q  <= 1'b0;
            woke_q      <= 1'b0;
            stopped_q   <= 1'b0;
        end else begin
            nmi_prev_q <= nmi_n;
            if (nmi_prev_q && !nmi_n) begin
                nmi_pend_q <= 1'b1;
            end else if (start && cause_d == `CBSI_CA_NMI) begin
                nmi_pend_q <= 1'b0;
            end
            if (!abort_n && phi2_out) begin
                abort_lat_q <= 1'b1;
            end else if (seq_go && cause_q == `CBSI_CA_ABT && cnt_q == 3'h1) begin
                abort_lat_q <= 1'b0;
            end
            if (wr_ops && reg_wdata[`CBSI_OP_BRK]) begin
                brk_pend_q <= 1'b1;
            end else if (start && cause_d == `CBSI_CA_BRK) begin
                brk_pend_q <= 1'b0;
            end
            if (wr_ops && reg_wdata[`CBSI_OP_COP]) begin
                cop_pend_q <= 1'b1;
            end else if (start && cause_d == `CBSI_CA_COP) begin
                cop_pend_q <= 1'b0;
            end
            if (wr_ops && reg_wdata[`CBSI_OP_SLEEP] && !wake) begin
                sleeping_q <= 1'b1;
            end else if (wake) begin
                sleeping_q <= 1'b0;
            end
            if (sleeping_q && wake) begin
                woke_q <= 1'b1;
            end else if (!core_stall) begin
                woke_q <= 1'b0;
            end
            if (wr_ops && reg_wdata[`CBSI_OP_HALT]) begin
                stopped_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cause priority
    always @* begin
        take    = 1'b0;
        cause_d = `CBSI_CA_RST;
        if (rst_pend_q) begin
            take = 1'b1;
        end else if (at_bound) begin
            if (abort_lat_q) begin
                take    = 1'b1;
                cause_d = `CBSI_CA_ABT;
            end else if (nmi_pend_q) begin
                take    = 1'b1;
                cause_d = `CBSI_CA_NMI;
            end else if (irq_req) begin
                take    = 1'b1;
                cause_d = `CBSI_CA_IRQ;
            end else if (brk_pend_q) begin
                take    = 1'b1;
                cause_d = `CBSI_CA_BRK;
            end else if (cop_pend_q) begin
                take    = 1'b1;
                cause_d = `CBSI_CA_COP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt sequencer
    assign last_cnt   = e_q ? `CBSI_SEQ_LAST_L : `CBSI_SEQ_LAST_N;
    assign vec_cnt    = last_cnt - 3'h1;
    assign start      = take && state_q == ST_IDLE && !core_stall;
    assign seq_go     = state_q == ST_SEQ && !core_stall;
    assign seq_end    = seq_go && cnt_q == last_cnt;
    assign pushing    = cnt_q >= `CBSI_SEQ_FIRST_PUSH && cnt_q < vec_cnt;
    assign seq_active = state_q == ST_SEQ;
    assign commit_block = abort_lat_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 3'h0;
            cause_q    <= `CBSI_CA_RST;
            rst_pend_q <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q    <= ST_SEQ;
                        cnt_q      <= 3'h0;
                        cause_q    <= cause_d;
                        rst_pend_q <= 1'b0;
                    end
                end
                default: begin
                    if (seq_end) begin
                        state_q <= ST_IDLE;
                    end else if (seq_go) begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cycle outputs
    assign stack_addr = {8'h00, e_q ? `CBSI_RST_SH : sp_q[15:8], sp_q[7:0]};

    always @* begin
        kind_d = core_kind;
        rw_d   = ~core_write;
        vp_n_d = 1'b1;
        addr_d = 24'h00_0000;
        if (state_q == ST_SEQ) begin
            if (cnt_q < `CBSI_SEQ_FIRST_PUSH) begin
                kind_d = `CBSI_KIND_INT;
                rw_d   = 1'b1;
            end else if (pushing) begin
                kind_d = `CBSI_KIND_DATA;
                rw_d   = cause_q == `CBSI_CA_RST;
                addr_d = stack_addr;
            end else begin
                kind_d = `CBSI_KIND_DATA;
                rw_d   = 1'b1;
                vp_n_d = 1'b0;
                addr_d = {vec_base[23:1], cnt_q == last_cnt};
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            kind_q              <= `CBSI_KIND_INT;
            rw_out              <= 1'b1;
            vector_fetch_flag_n <= 1'b1;
            seq_addr            <= 24'h00_0000;
            width_out           <= 1'b1;
        end else begin
            kind_q              <= kind_d;
            rw_out              <= rw_d;
            vector_fetch_flag_n <= vp_n_d;
            seq_addr            <= addr_d;
            width_out           <= phi2_out ? p_q[`CBSI_P_X] : p_q[`CBSI_P_M];
        end
    end

    assign data_address_valid    = kind_q[1];
    assign program_address_valid = kind_q[0];
    assign opcode_fetch_marker   = kind_q == `CBSI_KIND_FETCH;
    assign legacy_out            = e_q;

    ////////////////////////////////////////////////////////////////////
    // memory lock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_cnt_q <= 3'h0;
        end else if (rmw_final) begin
            lock_cnt_q <= p_q[`CBSI_P_M] ? `CBSI_LOCK_8BIT : `CBSI_LOCK_16BIT;
        end else if (lock_cnt_q != 3'h0 && !core_stall) begin
            lock_cnt_q <= lock_cnt_q - 3'h1;
        end
    end

    assign memory_lock_out_n = lock_cnt_q == 3'h0;

    ////////////////////////////////////////////////////////////////////
    // processor registers and bus writes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            p_q             <= `CBSI_RST_P;
            e_q             <= 1'b1;
            code_bank_reg_q <= `CBSI_RST_BANK;
            data_bank_reg_q <= `CBSI_RST_BANK;
            direct_q        <= `CBSI_RST_DIRECT;
            sp_q            <= {`CBSI_RST_SH, `CBSI_RST_SL};
            xh_q            <= `CBSI_RST_IDXHI;
            yh_q            <= `CBSI_RST_IDXHI;
            so_prev_q       <= 1'b1;
        end else begin
            so_prev_q <= set_ovf_n;
            if (reg_wr && !commit_block) begin
                if (reg_addr == `CBSI_OFS_STATUS) begin
                    p_q <= reg_wdata[7:0];
                end else if (reg_addr == `CBSI_OFS_MODE) begin
                    e_q <= reg_wdata[0];
                end else if (reg_addr == `CBSI_OFS_BANKS) begin
                    code_bank_reg_q <= reg_wdata[7:0];
                    data_bank_reg_q <= reg_wdata[15:8];
                end else if (reg_addr == `CBSI_OFS_DIRECT) begin
                    direct_q <= reg_wdata[15:0];
                end else if (reg_addr == `CBSI_OFS_STACK) begin
                    sp_q <= reg_wdata[15:0];
                end else if (reg_addr == `CBSI_OFS_INDEXHI) begin
                    xh_q <= reg_wdata[7:0];
                    yh_q <= reg_wdata[15:8];
                end
            end
            if (seq_go && pushing) begin
                sp_q <= sp_q - 16'h0001;
            end
            if (seq_end) begin
                p_q[`CBSI_P_I] <= 1'b1;
                p_q[`CBSI_P_D] <= 1'b0;
                if (!e_q) begin
                    code_bank_reg_q <= `CBSI_RST_BANK;
                end
            end
            if (e_q) begin
                p_q[`CBSI_P_M] <= 1'b1;
                p_q[`CBSI_P_X] <= 1'b1;
                sp_q[15:8]     <= `CBSI_RST_SH;
                xh_q           <= `CBSI_RST_IDXHI;
                yh_q           <= `CBSI_RST_IDXHI;
            end
            if (NARROW_BUS != 0 && so_prev_q && !set_ovf_n) begin
                p_q[`CBSI_P_V] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register reads
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `CBSI_OFS_STATUS) begin
                reg_rdata <= {24'h00_0000, p_q};
            end else if (reg_addr == `CBSI_OFS_MODE) begin
                reg_rdata <= {31'h0000_0000, e_q};
            end else if (reg_addr == `CBSI_OFS_BANKS) begin
                reg_rdata <= {16'h0000, data_bank_reg_q, code_bank_reg_q};
            end else if (reg_addr == `CBSI_OFS_DIRECT) begin
                reg_rdata <= {16'h0000, direct_q};
            end else if (reg_addr == `CBSI_OFS_STACK) begin
                reg_rdata <= {16'h0000, stack_addr[15:0]};
            end else if (reg_addr == `CBSI_OFS_INDEXHI) begin
                reg_rdata <= {16'h0000, yh_q, xh_q};
            end else if (reg_addr == `CBSI_OFS_STATE) begin
                reg_rdata <= {16'h0000, stall_q, stopped_q, sleeping_q,
                              abort_lat_q, nmi_pend_q, rst_pend_q,
                              cop_pend_q, brk_pend_q, state_q,
                              cnt_q, 1'b0, cause_q};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

// ===== rtl/cbsi_defs.vh
`ifndef CBSI_DEFS_VH
`define CBSI_DEFS_VH

// register offsets
`define CBSI_OFS_STATUS   8'h00
`define CBSI_OFS_MODE     8'h04
`define CBSI_OFS_BANKS    8'h08
`define CBSI_OFS_DIRECT   8'h0c
`define CBSI_OFS_STACK    8'h10
`define CBSI_OFS_INDEXHI  8'h14
`define CBSI_OFS_OPS      8'h18
`define CBSI_OFS_STATE    8'h1c

// status register bit positions
`define CBSI_P_C          0
`define CBSI_P_Z          1
`define CBSI_P_I          2
`define CBSI_P_D          3
`define CBSI_P_X          4
`define CBSI_P_M          5
`define CBSI_P_V          6
`define CBSI_P_N          7

// ops register bit positions
`define CBSI_OP_SLEEP     0
`define CBSI_OP_HALT      1
`define CBSI_OP_BRK       2
`define CBSI_OP_COP       3

// reset values
`define CBSI_RST_P        8'h34
`define CBSI_RST_BANK     8'h00
`define CBSI_RST_DIRECT   16'h0000
`define CBSI_RST_IDXHI    8'h00
`define CBSI_RST_SH       8'h01
`define CBSI_RST_SL       8'hff

// interrupt causes
`define CBSI_CA_RST       3'h0
`define CBSI_CA_ABT       3'h1
`define CBSI_CA_NMI       3'h2
`define CBSI_CA_IRQ       3'h3
`define CBSI_CA_BRK       3'h4
`define CBSI_CA_COP       3'h5

// vector low addresses, legacy then native
`define CBSI_VEC_ABT_L    24'h00_fff8
`define CBSI_VEC_ABT_N    24'h00_ffe8
`define CBSI_VEC_NMI_L    24'h00_fffa
`define CBSI_VEC_NMI_N    24'h00_ffea
`define CBSI_VEC_IRQ_L    24'h00_fffe
`define CBSI_VEC_IRQ_N    24'h00_ffee
`define CBSI_VEC_BRK_L    24'h00_fffe
`define CBSI_VEC_BRK_N    24'h00_ffe6
`define CBSI_VEC_COP_L    24'h00_fff4
`define CBSI_VEC_COP_N    24'h00_ffe4
`define CBSI_VEC_RST      24'h00_fffc

// cycle kinds {data_valid, program_valid}
`define CBSI_KIND_INT     2'h0
`define CBSI_KIND_PROG    2'h1
`define CBSI_KIND_DATA    2'h2
`define CBSI_KIND_FETCH   2'h3

// sequence timing
`define CBSI_SEQ_FIRST_PUSH 3'h2
`define CBSI_SEQ_LAST_L   3'h6
`define CBSI_SEQ_LAST_N   3'h7
`define CBSI_LOCK_8BIT    3'h3
`define CBSI_LOCK_16BIT   3'h5

`endif

// ===== rtl/cbsi_vec_sel.v
`timescale 1ns/100ps
`include "cbsi_defs.vh"

module cbsi_vec_sel (
    input  wire [2:0]  cause,
    input  wire        legacy,
    output reg  [23:0] vec
);

    // vector table lookup by cause and mode
    always @* begin
        case (cause)
            `CBSI_CA_ABT: vec = legacy ? `CBSI_VEC_ABT_L : `CBSI_VEC_ABT_N;
            `CBSI_CA_NMI: vec = legacy ? `CBSI_VEC_NMI_L : `CBSI_VEC_NMI_N;
            `CBSI_CA_IRQ: vec = legacy ? `CBSI_VEC_IRQ_L : `CBSI_VEC_IRQ_N;
            `CBSI_CA_BRK: vec = legacy ? `CBSI_VEC_BRK_L : `CBSI_VEC_BRK_N;
            `CBSI_CA_COP: vec = legacy ? `CBSI_VEC_COP_L : `CBSI_VEC_COP_N;
            default:      vec = `CBSI_VEC_RST;
        endcase
    end

endmodule

// ===== verification/cbsi_ctrl_asserts.sv
`timescale 1ns/100ps
module cbsi_ctrl_asserts (
    input wire        clk,
    input wire        reset_n,
    input wire        rmw_final,
    input wire [23:0] seq_addr,
    input wire [23:0] stack_addr,
    input wire        phi2_out,
    input wire        phi1_n_out,
    input wire        legacy_out,
    input wire        width_out,
    input wire        rw_out,
    input wire        data_address_valid,
    input wire        program_address_valid,
    input wire        opcode_fetch_marker,
    input wire        vector_fetch_flag_n,
    input wire        memory_lock_out_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    AST_RST_OUT: assert property ($rose(reset_n) |-> rw_out && vector_fetch_flag_n
        && legacy_out && width_out && !data_address_valid && !program_address_valid
        && !opcode_fetch_marker) else $error("outputs off reset levels");
    AST_RST_RW: assert property ($rose(reset_n) |-> rw_out [*8])
        else $error("store in reset sequence");
    AST_FETCH: assert property (opcode_fetch_marker ==
        (data_address_valid && program_address_valid)) else $error("fetch marker wrong");
    AST_VP_TWO: assert property ($fell(vector_fetch_flag_n) |=>
        !vector_fetch_flag_n ##1 vector_fetch_flag_n) else $error("vector flag length");
    AST_VP_READ: assert property (!vector_fetch_flag_n |-> rw_out
        && data_address_valid && !program_address_valid) else $error("vector cycle kind");
    AST_VP_PAIR: assert property ($fell(vector_fetch_flag_n) |-> !seq_addr[0]
        ##1 seq_addr == ($past(seq_addr) | 24'h00_0001)) else $error("vector pair order");
    AST_STACK: assert property (stack_addr[23:16] == 8'h00
        && (!legacy_out || stack_addr[15:8] == 8'h01)) else $error("stack out of range");
    AST_LOCK: assert property (rmw_final && legacy_out |=>
        !memory_lock_out_n [*3] ##1 memory_lock_out_n) else $error("lock length");
    AST_PHI: assert property ($past(reset_n) && $stable(phi2_out) |->
        phi2_out && !phi1_n_out) else $error("clock frozen wrong");
    AST_WIDTH: assert property (legacy_out && $past(legacy_out) |-> width_out)
        else $error("width status low");
endmodule

// ===== verification/cbsi_ctrl_tb.sv
`timescale 1ns/100ps
module cbsi_ctrl_tb;
    reg         clk, reset_n, reg_wr, reg_rd, irq_n, nmi_n, abort_n, set_ovf_n;
    reg         instr_boundary, rmw_final, hold_low, core_write;
    reg  [1:0]  core_kind;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg  [39:0] rows [0:6];
    wire [31:0] reg_rdata;
    wire [23:0] seq_addr;
    wire        rdy_in, rdy_out, rdy_oe, core_stall, commit_block, seq_active, phi2_out;
    wire        phi1_n_out, legacy_out, rw_out, data_address_valid, program_address_valid;
    wire        opcode_fetch_marker, vector_fetch_flag_n, memory_lock_out_n;
    integer     fail_count, checks_done, i, n;
    cbsi_ctrl cbsi_ctrl_inst (.stack_addr(), .width_out(), .*);
    cbsi_partner cbsi_partner_inst (.*);
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] s);
        checks_done = checks_done + 1;
        if (s !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task tk(input integer c);
        repeat (c) @(posedge clk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask
    task vw(input [23:0] e);
        n = 0;
        while (vector_fetch_flag_n !== 1'b0 && n < 100) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (n >= 100) begin
            fail_count = fail_count + 1;
            stop_test;
        end
        chk("vector", e, seq_addr);
        tk(4);
    endtask
    task bv(input [23:0] e);
        @(posedge clk);
        instr_boundary <= 1'b1;
        @(posedge clk);
        instr_boundary <= 1'b0;
        vw(e);
    endtask
    task lk(input integer e);
        @(posedge clk);
        rmw_final <= 1'b1;
        @(posedge clk);
        rmw_final <= 1'b0;
        #1;
        n = 0;
        while (memory_lock_out_n === 1'b0 && n < 9) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        chk("lock", e, n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, reset_n, reg_wr, reg_rd, instr_boundary, rmw_final, hold_low} = 7'h00;
        core_write = 1'b0;
        {irq_n, nmi_n, abort_n, set_ovf_n, core_kind, reg_addr, reg_wdata} = 46'h3c00_0000_0000;
        {fail_count, checks_done} = 0;
        rows[0] = 40'h00_0000_0034;
        rows[1] = 40'h04_0000_0001;
        rows[2] = 40'h08_0000_0000;
        rows[3] = 40'h0c_0000_0000;
        rows[4] = 40'h10_0000_01fc;
        rows[5] = 40'h14_0000_0000;
        rows[6] = 40'h20_0000_0000;
        tk(12);
        reset_n <= 1'b1;
        vw(24'h00_fffc);
        for (i = 0; i < 7; i = i + 1)
            rd(rows[i][39:32], rows[i][31:0]);
        wr(8'h00, 32'h0000_0030);
        irq_n <= 1'b0;
        bv(24'h00_fffe);
        irq_n <= 1'b1;
        rd(8'h00, 32'h0000_0034);
        wr(8'h18, 32'h0000_0004);
        bv(24'h00_fffe);
        wr(8'h18, 32'h0000_0008);
        bv(24'h00_fff4);
        abort_n <= 1'b0;
        tk(2);
        abort_n <= 1'b1;
        #1;
        chk("block", 1, commit_block);
        bv(24'h00_fff8);
        chk("block", 0, commit_block);
        set_ovf_n <= 1'b0;
        tk(2);
        set_ovf_n <= 1'b1;
        rd(8'h00, 32'h0000_0074);
        for (i = 0; i < 4; i = i + 1) begin
            core_kind <= i[1:0];
            tk(2);
            #1;
            chk("kind", i, {data_address_valid, program_address_valid});
            chk("fetch", i == 3, opcode_fetch_marker);
        end
        core_write <= 1'b1;
        tk(2);
        #1;
        chk("rw", 0, rw_out);
        hold_low <= 1'b1;
        tk(2);
        #1;
        chk("stall", 0, core_stall);
        core_write <= 1'b0;
        tk(2);
        #1;
        chk("rw", 1, rw_out);
        chk("stall", 1, core_stall);
        hold_low <= 1'b0;
        tk(4);
        #1;
        chk("stall", 0, core_stall);
        lk(3);
        wr(8'h04, 32'h0000_0000);
        #1;
        chk("legacy", 0, legacy_out);
        wr(8'h00, 32'h0000_0004);
        lk(5);
        wr(8'h18, 32'h0000_0004);
        bv(24'h00_ffe6);
        wr(8'h18, 32'h0000_0008);
        bv(24'h00_ffe4);
        wr(8'h00, 32'h0000_0000);
        {irq_n, nmi_n} <= 2'h0;
        bv(24'h00_ffea);
        wr(8'h00, 32'h0000_0000);
        bv(24'h00_ffee);
        {irq_n, nmi_n} <= 2'h3;
        wr(8'h00, 32'h0000_0004);
        wr(8'h18, 32'h0000_0001);
        tk(2);
        #1;
        chk("sleep", 0, rdy_in);
        irq_n <= 1'b0;
        tk(3);
        #1;
        chk("wake", 0, rdy_oe);
        chk("seq", 0, seq_active);
        irq_n <= 1'b1;
        hold_low <= 1'b1;
        tk(2);
        #1;
        chk("stall", 1, core_stall);
        hold_low <= 1'b0;
        tk(4);
        #1;
        chk("stall", 0, core_stall);
        wr(8'h18, 32'h0000_0002);
        tk(3);
        #1;
        chk("phi", 2, {phi2_out, phi1_n_out});
        chk("ready", 1, rdy_in);
        reset_n <= 1'b0;
        tk(3);
        #1;
        chk("phi", 1, {phi2_out, phi1_n_out});
        chk("outs", 7, {rw_out, vector_fetch_flag_n, legacy_out});
        reset_n <= 1'b1;
        vw(24'h00_fffc);
        stop_test;
    end
endmodule
bind cbsi_ctrl cbsi_ctrl_asserts cbsi_ctrl_asserts_inst (.*);

// ===== verification/cbsi_partner.sv
`timescale 1ns/100ps
module cbsi_partner (
    input  wire rdy_oe,
    input  wire rdy_out,
    input  wire hold_low,
    output wire rdy_in
);
    // pulled-up ready wire, either side may pull it low
    assign rdy_in = ((rdy_oe && !rdy_out) || hold_low) ? 1'b0 : 1'b1;
endmodule
